/* File: icsfll_pkg.sv */
// constants and carrier types shared by the internal clock generator files
`default_nettype none
//--------------------------------------------------------------------------
// Functional notes
// - system clock runs at twice bus rate
// - loop locks oscillator to 512 ticks per reference period
// - reference trimmed by nine bits total
// - bus divider field divides by 1,2,4,8
// - bus divider resets to divide by two
// - reset enters loop engaged mode
// - source select picks loop or reference
// - bypassed mode keeps loop running, reference out
// - bypassed low power disables loop, reference out
// - low power bit stops loop in bypass
// - stop disables loop and system clock
// - stop enable keeps reference running in stop
// - larger coarse trim lengthens reference period
// - fine trim bit adds smallest period step
// - source status follows select after synchronisation
// - divider change takes effect immediately
// - trim values survive ordinary reset
// - stop exit returns to previous mode
//--------------------------------------------------------------------------
package icsfll_pkg;
	//--------------------------------------------------------------
	// register byte offsets on the avalon slave
	//--------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
	localparam logic [3:0] ADDR_CTRL_TWO = 4'h4;
	localparam logic [3:0] ADDR_TRIM = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hC;
	//--------------------------------------------------------------
	// field positions
	//--------------------------------------------------------------
	localparam int SRC_SEL_BIT = 6;
	localparam int REF_STOP_EN_BIT = 0;
	localparam int BUS_DIV_LO = 6;
	localparam int LOW_POWER_BIT = 3;
	localparam int SRC_STATUS_BIT = 2;
	localparam int FINE_TRIM_BIT = 0;
	//--------------------------------------------------------------
	// values after reset
	//--------------------------------------------------------------
	localparam logic [1:0] BUS_DIV_RST = 2'h1;
	localparam logic [7:0] TRIM_RST = 8'h80;
	localparam logic FINE_TRIM_RST = 1'b0;
	localparam logic [15:0] DCO_INC_INIT = 16'h10C6;
	//--------------------------------------------------------------
	// timing and loop constants
	//--------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int REF_PERIOD_PS = 31250000;
	localparam int REF_PERIOD_CYC = REF_PERIOD_PS / CLK_PERIOD_PS;
	localparam logic [15:0] TRIM_CENTRE = 16'h0100;
	localparam logic [11:0] FLL_MULT = 12'h200;
	//--------------------------------------------------------------
	// types
	//--------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ENGAGED,
		MODE_BYPASSED,
		MODE_BYPASSED_LP,
		MODE_STOP
	} icsfll_mode_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} icsfll_avreq_t;
	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} icsfll_avrsp_t;
	typedef struct packed {
		logic sys_clk_en;
		logic bus_clk_en;
		logic ref_clk_en;
		logic fll_on;
		logic fll_locked;
		logic src_status;
	} icsfll_clk_t;
endpackage
`default_nettype wire

/* File: icsfll_bus_div.sv */
// power-of-two divider giving the system output clock and the bus clock
`timescale 1ns/100ps
`default_nettype none
module icsfll_bus_div
	import icsfll_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic srst, // synchronous reset
	input wire logic src_en, // tick of the selected source
	input wire logic [1:0] div_sel, // divide select
	output logic out_en, // system output clock tick
	output logic bus_en // bus clock tick
);
	typedef struct packed {
		logic [2:0] cnt;
		logic phase;
		logic out_en;
		logic bus_en;
	} icsfll_div_st_t;

	icsfll_div_st_t st_reg;
	icsfll_div_st_t st_next;

	// mask of the counter bits used by a divide select
	function automatic logic [2:0] div_mask(input logic [1:0] sel);
		case (sel)
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	endfunction

	//--------------------------------------------------------------
	// divide logic
	//--------------------------------------------------------------
	// select is read live, so a new ratio acts on the next tick
	always_comb
	begin
		st_next = st_reg;
		st_next.out_en = 1'b0;
		st_next.bus_en = 1'b0;
		if (src_en)
		begin
			if ((st_reg.cnt & div_mask(div_sel)) == div_mask(div_sel))
			begin
				st_next.cnt = 3'h0;
				st_next.out_en = 1'b1;
				st_next.phase = ~st_reg.phase;
				st_next.bus_en = st_reg.phase;
			end
			else
			begin
				st_next.cnt = st_reg.cnt + 3'h1;
			end
		end
		if (srst)
		begin
			st_next = '0;
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		st_reg <= st_next;
	end

	assign out_en = st_reg.out_en;
	assign bus_en = st_reg.bus_en;

	a_div_by_one: assert property (@(posedge clk) disable iff (srst)
		(src_en && div_sel == 2'h0) |=> out_en)
		else $error("divide by one missed a source tick");
	a_bus_half: assert property (@(posedge clk) disable iff (srst)
		bus_en |-> out_en)
		else $error("bus tick without output tick");
	a_bus_alt: assert property (@(posedge clk) disable iff (srst)
		(out_en && $past(out_en) && !$past(srst)) |-> (bus_en != $past(bus_en)))
		else $error("bus tick not every second output tick");
endmodule // icsfll_bus_div
`default_nettype wire

/* File: icsfll_top.sv */
// internal clock generator: reference, locked loop, source mux and registers
`timescale 1ns/100ps
`default_nettype none
module icsfll_top
	import icsfll_pkg::*;
#(
	parameter int REF_CYC = REF_PERIOD_CYC // nominal reference period in cycles
)
(
	input wire logic clk, // system clock
	input wire logic srst, // synchronous reset, trims kept
	input wire logic por, // power-on reset, clears trims too
	input wire logic stop_req, // processor in stop
	input wire icsfll_avreq_t av_req, // avalon request
	output icsfll_avrsp_t av_rsp, // avalon response
	output icsfll_clk_t clk_out // clock ticks and status
);
	typedef struct packed {
		logic src_sel;
		logic ref_stop_en;
		logic [1:0] bus_div;
		logic low_power;
		logic [7:0] trim;
		logic fine_trim;
		logic [1:0] status_sync;
		logic src_status;
		icsfll_mode_t mode;
		logic [15:0] ref_cnt;
		logic [15:0] dco_acc;
		logic [15:0] dco_inc;
		logic [11:0] dco_cnt;
		logic fll_locked;
		icsfll_avrsp_t rsp;
		icsfll_clk_t outs;
	} icsfll_st_t;

	icsfll_st_t st_reg;
	icsfll_st_t st_next;
	logic src_en;
	logic div_out;
	logic div_bus;
	logic ref_tick;
	logic fll_run;

	// byte address match for an aligned word
	function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
		hit = (addr == off);
	endfunction

	// readback of one register, unimplemented bits as zero
	function automatic logic [7:0] read_mux(input icsfll_st_t s, input logic [3:0] addr);
		read_mux = 8'h00;
		if (hit(addr, ADDR_CTRL_ONE))
		begin
			read_mux[SRC_SEL_BIT] = s.src_sel;
			read_mux[REF_STOP_EN_BIT] = s.ref_stop_en;
		end
		else if (hit(addr, ADDR_CTRL_TWO))
		begin
			read_mux[BUS_DIV_LO +: 2] = s.bus_div;
			read_mux[LOW_POWER_BIT] = s.low_power;
		end
		else if (hit(addr, ADDR_TRIM))
		begin
			read_mux = s.trim;
		end
		else if (hit(addr, ADDR_STATUS))
		begin
			read_mux[SRC_STATUS_BIT] = s.src_status;
			read_mux[FINE_TRIM_BIT] = s.fine_trim;
		end
	endfunction

	//--------------------------------------------------------------
	// bus divider
	//--------------------------------------------------------------
	icsfll_bus_div u_div (
		.clk(clk),
		.srst(srst || por),
		.src_en(src_en),
		.div_sel(st_reg.bus_div),
		.out_en(div_out),
		.bus_en(div_bus)
	);

	//--------------------------------------------------------------
	// next state
	//--------------------------------------------------------------
	always_comb
	begin
		logic [15:0] ref_period;
		logic ref_run;
		logic [16:0] dco_sum;
		logic dco_tick;
		logic [11:0] dco_total;
		logic wr_now;
		// defaults for the local terms
		ref_period = 16'h0000;
		ref_run = 1'b0;
		dco_sum = 17'h00000;
		dco_tick = 1'b0;
		dco_total = 12'h000;
		wr_now = 1'b0;
		st_next = st_reg;
		ref_period = 16'(REF_CYC) + 16'({st_reg.trim, st_reg.fine_trim}) - TRIM_CENTRE;
		// reference halts in stop unless its stop enable is set
		ref_run = (st_reg.mode != MODE_STOP) || st_reg.ref_stop_en;
		ref_tick = ref_run && (st_reg.ref_cnt >= ref_period - 16'h0001);
		if (ref_run)
		begin
			st_next.ref_cnt = ref_tick ? 16'h0000 : st_reg.ref_cnt + 16'h0001;
		end
		// loop runs when engaged, or bypassed without low power
		fll_run = (st_reg.mode == MODE_ENGAGED) || (st_reg.mode == MODE_BYPASSED);
		dco_sum = {1'b0, st_reg.dco_acc} + {1'b0, st_reg.dco_inc};
		dco_tick = fll_run && dco_sum[16];
		dco_total = st_reg.dco_cnt + {11'h000, dco_tick};
		if (fll_run)
		begin
			st_next.dco_acc = dco_sum[15:0];
			st_next.dco_cnt = dco_total;
			// per reference period, steer the oscillator toward 512 ticks
			if (ref_tick)
			begin
				st_next.dco_cnt = 12'h000;
				st_next.fll_locked = (dco_total == FLL_MULT);
				if (dco_total < FLL_MULT)
				begin
					st_next.dco_inc = st_reg.dco_inc + 16'h0001;
				end
				else if (dco_total > FLL_MULT)
				begin
					st_next.dco_inc = st_reg.dco_inc - 16'h0001;
				end
			end
		end
		else
		begin
			st_next.dco_cnt = 12'h000;
			st_next.fll_locked = 1'b0;
		end
		// source switch crosses into the reference domain before use
		if (ref_tick)
		begin
			st_next.status_sync = {st_reg.status_sync[0], st_reg.src_sel};
			st_next.src_status = st_reg.status_sync[1];
		end
		// selected source feeds the divider, nothing in stop
		src_en = (st_reg.mode != MODE_STOP) && (st_reg.src_status ? ref_tick : dco_tick);
		// mode follows the registers, so stop exit restores it
		if (stop_req)
		begin
			st_next.mode = MODE_STOP;
		end
		else if (!st_reg.src_sel)
		begin
			st_next.mode = MODE_ENGAGED;
		end
		else
		begin
			st_next.mode = st_reg.low_power ? MODE_BYPASSED_LP : MODE_BYPASSED;
		end
		// avalon slave: one wait cycle, then answer
		wr_now = av_req.write && !st_reg.rsp.waitrequest && av_req.byteenable[0];
		if (st_reg.rsp.waitrequest)
		begin
			if (av_req.read || av_req.write)
			begin
				st_next.rsp.waitrequest = 1'b0;
				st_next.rsp.readdata = {24'h000000, read_mux(st_reg, av_req.address)};
			end
		end
		else
		begin
			st_next.rsp.waitrequest = 1'b1;
		end
		// writes touch only implemented fields
		if (wr_now && hit(av_req.address, ADDR_CTRL_ONE))
		begin
			st_next.src_sel = av_req.writedata[SRC_SEL_BIT];
			st_next.ref_stop_en = av_req.writedata[REF_STOP_EN_BIT];
		end
		if (wr_now && hit(av_req.address, ADDR_CTRL_TWO))
		begin
			st_next.bus_div = av_req.writedata[BUS_DIV_LO +: 2];
			st_next.low_power = av_req.writedata[LOW_POWER_BIT];
		end
		if (wr_now && hit(av_req.address, ADDR_TRIM))
		begin
			st_next.trim = av_req.writedata[7:0];
		end
		if (wr_now && hit(av_req.address, ADDR_STATUS))
		begin
			st_next.fine_trim = av_req.writedata[FINE_TRIM_BIT];
		end
		// registered outputs
		st_next.outs.sys_clk_en = div_out;
		st_next.outs.bus_clk_en = div_bus;
		st_next.outs.ref_clk_en = ref_tick;
		st_next.outs.fll_on = fll_run;
		st_next.outs.fll_locked = st_reg.fll_locked;
		st_next.outs.src_status = st_reg.src_status;
		// reset: trims only cleared at power-on
		if (srst || por)
		begin
			st_next = '0;
			st_next.bus_div = BUS_DIV_RST;
			st_next.mode = MODE_ENGAGED;
			st_next.dco_inc = DCO_INC_INIT;
			st_next.rsp.waitrequest = 1'b1;
			st_next.trim = por ? TRIM_RST : st_reg.trim;
			st_next.fine_trim = por ? FINE_TRIM_RST : st_reg.fine_trim;
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		st_reg <= st_next;
	end

	assign av_rsp = st_reg.rsp;
	assign clk_out = st_reg.outs;

	// helper for the trim check: any write requested in this cycle, delayed by $past in the check
	logic wr_any;
	assign wr_any = av_req.write;

	//--------------------------------------------------------------
	// checks
	//--------------------------------------------------------------
	a_bus_divider_select_reset: assert property (@(posedge clk) disable iff (srst || por)
		$past(srst) |-> (st_reg.bus_div == 2'h1))
		else $error("bus divider not divide by two after reset");
	a_engaged_reset: assert property (@(posedge clk) disable iff (srst || por)
		$past(srst) |-> (st_reg.mode == MODE_ENGAGED && !st_reg.src_sel))
		else $error("not in loop engaged mode after reset");
	a_bypass_loop_on: assert property (@(posedge clk) disable iff (srst || por)
		(st_reg.mode == MODE_BYPASSED) |=> clk_out.fll_on)
		else $error("loop stopped in bypassed mode");
	a_lowpwr_loop_off: assert property (@(posedge clk) disable iff (srst || por)
		(st_reg.mode == MODE_BYPASSED_LP) |=> (!clk_out.fll_on && !st_reg.fll_locked))
		else $error("loop running in bypassed low power mode");
	a_stop_quiet: assert property (@(posedge clk) disable iff (srst || por)
		(st_reg.mode == MODE_STOP)[*2] |=> (!clk_out.sys_clk_en && !clk_out.fll_on))
		else $error("system clock or loop active in stop");
	a_ref_stopped: assert property (@(posedge clk) disable iff (srst || por)
		(st_reg.mode == MODE_STOP && !st_reg.ref_stop_en) |=> !clk_out.ref_clk_en)
		else $error("reference ran in stop without stop enable");
	a_trim_kept: assert property (@(posedge clk) disable iff (por)
		(srst && !$past(wr_any)) |=> (st_reg.trim == $past(st_reg.trim)))
		else $error("trim lost on ordinary reset");
	a_status_sync: assert property (@(posedge clk) disable iff (srst || por)
		(st_reg.src_status != $past(st_reg.src_status)) |-> $past(ref_tick))
		else $error("source status changed without synchronisation");
	a_stop_return: assert property (@(posedge clk) disable iff (srst || por)
		(st_reg.mode == MODE_STOP && !stop_req && !st_reg.src_sel) |=> (st_reg.mode == MODE_ENGAGED))
		else $error("stop exit did not restore the previous mode");

	// system tick output is the divider tick one register later
	a_sys_from_div: assert property (@(posedge clk) disable iff (srst || por)
		(!$past(srst) && !$past(por)) |-> (clk_out.sys_clk_en == $past(div_out)))
		else $error("system tick output does not follow the divider");
	// loop state output mirrors the mode decode
	a_loop_track: assert property (@(posedge clk) disable iff (srst || por)
		(!$past(srst) && !$past(por)) |-> (clk_out.fll_on == $past(fll_run)))
		else $error("loop running flag does not follow the mode");
	// no source tick may reach the divider in stop
	a_stop_no_src: assert property (@(posedge clk) disable iff (srst || por)
		(st_reg.mode == MODE_STOP) |-> !src_en)
		else $error("source tick passed to the divider in stop");
	// upper read data bits are always driven as zero
	a_read_upper: assert property (@(posedge clk) disable iff (srst || por)
		!av_rsp.waitrequest |-> (av_rsp.readdata[31:8] == 24'h000000))
		else $error("unimplemented read data bits not zero");
endmodule // icsfll_top
`default_nettype wire

/* File: icsfll_top_note_end.sv */
// no logic of its own: only switches implicit nets off and on again
`default_nettype none
`default_nettype wire

/* File: icsfll_consumer.sv */
// clock consumer model: records spacing of the generated ticks and number of system and reference ticks
`timescale 1ns/100ps
`default_nettype none
module icsfll_consumer
	import icsfll_pkg::*;
(
	input wire logic clk, // system clock
	input wire icsfll_clk_t ticks, // ticks from the generator
	output logic [31:0] sys_gap, // cycles between last two system ticks
	output logic [31:0] bus_gap, // cycles between last two bus ticks
	output logic [31:0] ref_gap, // cycles between last two reference ticks
	output logic [31:0] sys_cnt, // system ticks seen
	output logic [31:0] ref_cnt // reference ticks seen
);
	logic [31:0] now = 32'h0;
	logic [31:0] sys_at = 32'h0;
	logic [31:0] bus_at = 32'h0;
	logic [31:0] ref_at = 32'h0;
	initial sys_cnt = 32'h0;
	initial ref_cnt = 32'h0;
	// stamp each tick and keep the gap to the one before
	// plain always, as the counters also carry start values
	always @(posedge clk)
	begin
		now <= now + 32'h1;
		if (ticks.sys_clk_en)
		begin
			sys_gap <= now - sys_at;
			sys_at <= now;
			sys_cnt <= sys_cnt + 32'h1;
		end
		if (ticks.bus_clk_en)
		begin
			bus_gap <= now - bus_at;
			bus_at <= now;
		end
		if (ticks.ref_clk_en)
		begin
			ref_gap <= now - ref_at;
			ref_at <= now;
			ref_cnt <= ref_cnt + 32'h1;
		end
	end
endmodule // icsfll_consumer
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the internal clock generator
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import icsfll_pkg::*;
;
	localparam int RC = 300;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic por = 1'b1;
	logic stop_req = 1'b0;
	icsfll_avreq_t av_req = '0;
	icsfll_avrsp_t av_rsp;
	icsfll_clk_t clk_out;
	logic [31:0] sys_gap, bus_gap, ref_gap, sys_cnt, ref_cnt, rd;
	int n_errors = 0;
	int compares = 0;
	//----------------------------------------------------------------
	// clock, design and consumer
	//----------------------------------------------------------------
	// 250 MHz clock
	always #2 clk = ~clk;
	icsfll_top #(.REF_CYC(RC)) uut (.clk(clk), .srst(srst), .por(por), .stop_req(stop_req),
		.av_req(av_req), .av_rsp(av_rsp), .clk_out(clk_out));
	icsfll_consumer cons (.clk(clk), .ticks(clk_out), .sys_gap(sys_gap), .bus_gap(bus_gap),
		.ref_gap(ref_gap), .sys_cnt(sys_cnt), .ref_cnt(ref_cnt));
	//----------------------------------------------------------------
	// shared tasks
	//----------------------------------------------------------------
	task automatic end_sim;
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		av_req.read <= !wr;
		av_req.write <= wr;
		av_req.address <= addr;
		av_req.byteenable <= 4'hF;
		av_req.writedata <= {24'h0, wd};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (av_rsp.waitrequest !== 1'b0 && n < 50);
		rd = av_rsp.readdata;
		chk(n < 50, 1'b1, "bus answer");
		av_req.read <= 1'b0;
		av_req.write <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] addr, input logic [7:0] exp, input string what);
		bus(1'b0, addr, 8'h00);
		chk(rd, {24'h0, exp}, what);
	endtask
	task automatic do_reset(input logic p);
		@(posedge clk);
		srst <= 1'b1;
		por <= p;
		cyc(6);
		srst <= 1'b0;
		por <= 1'b0;
	endtask
	//----------------------------------------------------------------
	// scenarios
	//----------------------------------------------------------------
	task automatic t_reset(input logic [7:0] trim);
		rchk(ADDR_CTRL_ONE, 8'h00, "ctrl one reset");
		rchk(ADDR_CTRL_TWO, 8'h40, "ctrl two reset");
		rchk(ADDR_TRIM, trim, "trim after reset");
		rchk(ADDR_STATUS, 8'h00, "status reset");
		rchk(4'h2, 8'h00, "unmapped read");
		chk(clk_out.fll_on, 1'b1, "loop on after reset");
	endtask
	task automatic t_reserved;
		bus(1'b1, ADDR_CTRL_ONE, 8'hFF);
		rchk(ADDR_CTRL_ONE, 8'h41, "ctrl one bits");
		bus(1'b1, ADDR_CTRL_TWO, 8'hFF);
		rchk(ADDR_CTRL_TWO, 8'hC8, "ctrl two bits");
		bus(1'b1, ADDR_STATUS, 8'hFE);
		rchk(ADDR_STATUS, 8'h00, "status not yet switched");
		bus(1'b1, ADDR_CTRL_ONE, 8'h00);
		bus(1'b1, ADDR_CTRL_TWO, 8'h40);
		cyc(5 * RC);
	endtask
	// reference source through every divider setting
	task automatic t_divider;
		bus(1'b1, ADDR_CTRL_ONE, 8'h40);
		rchk(ADDR_STATUS, 8'h00, "status before sync");
		cyc(4 * RC);
		rchk(ADDR_STATUS, 8'h04, "status after sync");
		chk(clk_out.src_status, 1'b1, "status output");
		for (int d = 0; d < 4; d++)
		begin
			bus(1'b1, ADDR_CTRL_TWO, 8'(d << 6));
			cyc(5 * (RC << d) + 50);
			chk(sys_gap, RC << d, "system tick spacing");
			chk(bus_gap, 2 * (RC << d), "bus tick spacing");
			chk(clk_out.fll_on, 1'b1, "loop kept in bypass");
		end
		bus(1'b1, ADDR_CTRL_TWO, 8'h48);
		cyc(4);
		chk(clk_out.fll_on, 1'b0, "loop off in low power");
		chk(clk_out.fll_locked, 1'b0, "no lock in low power");
		cyc(5 * RC);
		chk(sys_gap, 2 * RC, "reference drives low power");
		bus(1'b1, ADDR_CTRL_TWO, 8'h40);
		cyc(4);
		chk(clk_out.fll_on, 1'b1, "loop back on");
	endtask
	task automatic t_trim(input logic [7:0] trim, input logic fine);
		bus(1'b1, ADDR_TRIM, trim);
		bus(1'b1, ADDR_STATUS, {7'h0, fine});
		cyc(4 * RC);
		chk(ref_gap, RC + {trim, fine} - 256, "reference period");
		rchk(ADDR_STATUS, {5'h0, 1'b1, 1'b0, fine}, "fine trim read");
	endtask
	task automatic t_engaged;
		cyc(4 * RC);
		chk(clk_out.src_status, 1'b0, "loop in use");
		chk(sys_gap < RC, 1'b1, "loop faster than reference");
	endtask
	// stop entry and exit, reference kept or not
	task automatic t_stop(input logic keep, input logic sel);
		logic [31:0] s;
		logic [31:0] r;
		bus(1'b1, ADDR_CTRL_ONE, {1'b0, sel, 5'h0, keep});
		cyc(4 * RC);
		stop_req <= 1'b1;
		cyc(5);
		chk(clk_out.fll_on, 1'b0, "loop off in stop");
		s = sys_cnt;
		r = ref_cnt;
		cyc(3 * RC);
		chk(sys_cnt, s, "no system ticks in stop");
		chk(ref_cnt != r, keep, "reference in stop");
		stop_req <= 1'b0;
		cyc(6 * RC);
		chk(clk_out.src_status, sel, "mode after stop");
		chk(clk_out.fll_on, 1'b1, "loop after stop");
		chk(sys_gap < RC, !sel, "ticks after stop");
	endtask
	//----------------------------------------------------------------
	// main sequence and watchdog
	//----------------------------------------------------------------
	// run all scenarios in turn
	initial
	begin
		cyc(6);
		srst <= 1'b0;
		por <= 1'b0;
		t_reset(8'h80);
		t_reserved;
		t_engaged;
		t_divider;
		t_trim(8'h81, 1'b1);
		t_trim(8'h7F, 1'b0);
		do_reset(1'b0);
		t_reset(8'h7F);
		t_stop(1'b1, 1'b0);
		t_stop(1'b0, 1'b1);
		do_reset(1'b1);
		t_reset(8'h80);
		end_sim;
	end
	// cut a hang short
	initial
	begin
		cyc(95000);
		n_errors++;
		end_sim;
	end
endmodule // tb_top
`default_nettype wire
